/* src/panel_led_ctrl.sv */
// Front-panel lamp controller for the 28-port switch, with AXI4-Lite registers.
// Assumes all status inputs are synchronous to aclk and activity inputs are pulses.
`timescale 1ns/10ps
module panel_led_ctrl
    import panel_led_pkg::*;
#(
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status sources
    input wire logic cpu_running,
    input wire logic fan_ok,
    input wire logic fan_fail,
    input wire logic [ALL_PORTS-1:0] link_up,
    input wire logic [ALL_PORTS-1:0] activity,
    input wire logic [2*ALL_PORTS-1:0] port_speed,
    input wire logic [FAST_PORTS-1:0] pd_detect,
    input wire logic [FAST_PORTS-1:0] pd_fault,
    input wire logic [SHARED_PORTS-1:0] module_present,
    // Lamps and controls
    output logic system_indicator,
    output logic fan_ok_lamp,
    output logic fan_fail_lamp,
    output logic power_budget_full_lamp,
    output logic [ALL_PORTS-1:0] link_activity_lamp,
    output logic [ALL_PORTS-1:0] speed100_lamp,
    output logic [GIG_PORTS-1:0] speed1000_lamp,
    output logic [FAST_PORTS-1:0] poe_green_lamp,
    output logic [FAST_PORTS-1:0] poe_red_lamp,
    output logic [FAST_PORTS-1:0] poe_power_en,
    output logic [SHARED_PORTS-1:0] pluggable_module_slot_lamp,
    output logic [SHARED_PORTS-1:0] fiber_select,
    output logic [SHARED_PORTS-1:0] copper_enable
);
    // Register state
    logic idle_level_r;
    logic [POWER_W-1:0] power_r;
    logic [FAST_PORTS-1:0] poe_en_r;

    // AXI4-Lite write path
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    wire b_done = s_axi_bvalid && s_axi_bready;

    // Write decode; unmapped or read-only addresses answer SLVERR
    wire wr_ctrl = do_write && waddr_r == CTRL_OFS;
    wire wr_power = do_write && waddr_r == POWER_OFS;
    wire wr_poe_en = do_write && waddr_r == POE_EN_OFS;
    wire wr_mapped = wr_ctrl || wr_power || wr_poe_en;

    // Byte-lane merge for a partial write
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    wire [31:0] power_merged = merge({20'h00000, power_r}, wdata_r, wstrb_r);
    wire [31:0] poe_en_merged = merge({8'h00, poe_en_r}, wdata_r, wstrb_r);
    wire [31:0] ctrl_merged = merge({31'h0, idle_level_r}, wdata_r, wstrb_r);

    // Address and data are held separately, so either may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (aw_take) begin
                aw_have_r <= 1'b1;
                waddr_r <= {s_axi_awaddr[7:2], 2'h0};
                s_axi_awready <= 1'b0;
            end else if (b_done) begin
                aw_have_r <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (b_done) begin
                w_have_r <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Response is raised one edge after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software-written registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_level_r <= CTRL_IDLE_LEVEL_RST;
            power_r <= POWER_RST;
            poe_en_r <= POE_EN_RST;
        end else begin
            if (wr_ctrl) begin
                idle_level_r <= ctrl_merged[CTRL_IDLE_LEVEL_BIT];
            end
            if (wr_power) begin
                power_r <= power_merged[POWER_W-1:0];
            end
            if (wr_poe_en) begin
                poe_en_r <= poe_en_merged[FAST_PORTS-1:0];
            end
        end
    end

    // AXI4-Lite read path
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_BUDGET_FULL_BIT] = power_budget_full_lamp;
        status_word[STAT_FAN_OK_BIT] = fan_ok_lamp;
        status_word[STAT_FAN_FAIL_BIT] = fan_fail_lamp;
        status_word[STAT_CPU_RUN_BIT] = cpu_running;
        status_word[STAT_MODULE_BIT +: SHARED_PORTS] = module_present;
    end

    wire [7:0] raddr = {s_axi_araddr[7:2], 2'h0};
    wire rd_mapped = raddr == CTRL_OFS || raddr == POWER_OFS || raddr == STATUS_OFS ||
                     raddr == POE_EN_OFS || raddr == LINK_OFS || raddr == SOURCING_OFS;
    wire [31:0] rd_mux = raddr == CTRL_OFS ? {31'h0, idle_level_r} :
                         raddr == POWER_OFS ? {20'h00000, power_r} :
                         raddr == STATUS_OFS ? status_word :
                         raddr == POE_EN_OFS ? {8'h00, poe_en_r} :
                         raddr == LINK_OFS ? {4'h0, link_up} :
                         raddr == SOURCING_OFS ? {8'h00, poe_power_en} : 32'h00000000;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // One read at a time; arready returns once the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // Blink timebase
    logic [31:0] blink_cnt_r;
    logic blink_tick;
    localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);

    // One shared tick keeps every blinking lamp in step on the panel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_r <= 32'h00000000;
            blink_tick <= 1'b0;
        end else if (blink_cnt_r >= BLINK_LAST) begin
            blink_cnt_r <= 32'h00000000;
            blink_tick <= 1'b1;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h00000001;
            blink_tick <= 1'b0;
        end
    end

    // System and fan lamps
    wire ind_nxt = cpu_running ? (blink_tick ? !system_indicator : system_indicator)
                               : idle_level_r;
    wire budget_full_nxt = power_r >= POWER_FULL_DW;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_indicator <= 1'b0;
            fan_ok_lamp <= 1'b0;
            fan_fail_lamp <= 1'b0;
            power_budget_full_lamp <= 1'b0;
        end else begin
            system_indicator <= ind_nxt;
            fan_ok_lamp <= fan_ok;
            fan_fail_lamp <= fan_fail;
            power_budget_full_lamp <= budget_full_nxt;
        end
    end

    // Per-port link/activity
    genvar p;
    generate
        for (p = 0; p < ALL_PORTS; p++) begin : g_port
            port_activity_lamp u_lamp (
                .aclk(aclk),
                .aresetn(aresetn),
                .blink_tick(blink_tick),
                .link_up(link_up[p]),
                .activity(activity[p]),
                .lamp_r(link_activity_lamp[p])
            );
        end
    endgenerate

    // Speed lamps
    logic [ALL_PORTS-1:0] is_100;
    logic [GIG_PORTS-1:0] is_1000;
    always_comb begin
        for (int i = 0; i < ALL_PORTS; i++) begin
            is_100[i] = link_up[i] && port_speed[2*i +: 2] == SPEED_100;
        end
        for (int g = 0; g < GIG_PORTS; g++) begin
            is_1000[g] = link_up[FAST_PORTS+g] &&
                         port_speed[2*(FAST_PORTS+g) +: 2] == SPEED_1000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed100_lamp <= '0;
            speed1000_lamp <= '0;
        end else begin
            speed100_lamp <= is_100;
            speed1000_lamp <= is_1000;
        end
    end

    // Power sourcing
    // A granted port keeps power while healthy; a full budget only blocks new grants
    wire [FAST_PORTS-1:0] healthy = pd_detect & ~pd_fault & poe_en_r;
    wire [FAST_PORTS-1:0] sourcing_nxt =
        healthy & (poe_power_en | {FAST_PORTS{!power_budget_full_lamp}});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            poe_power_en <= '0;
            poe_green_lamp <= '0;
            poe_red_lamp <= '0;
        end else begin
            poe_power_en <= sourcing_nxt;
            poe_green_lamp <= sourcing_nxt;
            poe_red_lamp <= pd_detect & pd_fault;
        end
    end

    // Shared port media
    // Fibre wins over copper as soon as a module is seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pluggable_module_slot_lamp <= '0;
            fiber_select <= '0;
            copper_enable <= '1;
        end else begin
            pluggable_module_slot_lamp <= module_present;
            fiber_select <= module_present;
            copper_enable <= ~module_present;
        end
    end

    // Checks
    sequence s_tick_gap;
        blink_tick ##1 !blink_tick;
    endsequence

    chk_blink_tick_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        blink_tick && BLINK_CYC > 1 |-> s_tick_gap) else $error("blink ticks back to back");
    chk_ind_blinks: assert property (@(posedge aclk) disable iff (!aresetn)
        (cpu_running && blink_tick) |=> system_indicator != $past(system_indicator))
        else $error("system indicator missed a blink");
    chk_ind_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cpu_running ##1 !cpu_running) |-> system_indicator == $past(idle_level_r))
        else $error("system indicator not steady when processor stopped");
    chk_fan_lamps: assert property (@(posedge aclk) disable iff (!aresetn)
        fan_ok |=> fan_ok_lamp) else $error("fan ok lamp dark");
    chk_fan_fail_lamp: assert property (@(posedge aclk) disable iff (!aresetn)
        fan_fail |=> fan_fail_lamp) else $error("fan fail lamp dark");
    chk_budget_full_on: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_power && power_merged[POWER_W-1:0] >= POWER_FULL_DW |=> ##1 power_budget_full_lamp)
        else $error("budget lamp not lit at full consumption");
    chk_budget_full_off: assert property (@(posedge aclk) disable iff (!aresetn)
        power_r < POWER_FULL_DW |=> !power_budget_full_lamp)
        else $error("budget lamp lit below full mark");
    chk_no_new_power: assert property (@(posedge aclk) disable iff (!aresetn)
        power_budget_full_lamp |=> (poe_power_en & ~$past(poe_power_en)) == '0)
        else $error("new device powered while budget full");
    chk_poe_off_empty: assert property (@(posedge aclk) disable iff (!aresetn)
        pd_detect == '0 |=> (poe_green_lamp | poe_red_lamp) == '0)
        else $error("power lamp lit with no device");
    chk_poe_red_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        (pd_detect & pd_fault) != '0 |=> (poe_red_lamp & ~poe_green_lamp) != '0)
        else $error("fault not shown red");
    chk_module_media: assert property (@(posedge aclk) disable iff (!aresetn)
        module_present[0] |=> fiber_select[0] && !copper_enable[0] &&
                             pluggable_module_slot_lamp[0])
        else $error("module inserted but copper still active");
    chk_gig_speed: assert property (@(posedge aclk) disable iff (!aresetn)
        !link_up[FAST_PORTS] |=> !speed1000_lamp[0] && !speed100_lamp[FAST_PORTS])
        else $error("gigabit speed lamp lit without link");
endmodule : panel_led_ctrl

/* src/panel_led_pkg.sv */
// What this block does
// - System indicator blinks while the management processor reports it is running.
// - Processor stopped: system indicator holds steady on or off, software picks which.
// - Fan OK lamp lit while the fan monitor reports normal operation.
// - Fan fail lamp lit whenever the fan monitor reports a failed fan.
// - Budget-full lamp lights when consumption reaches 155 W (remaining budget 15.4 W or less).
// - While the budget is full, no newly attached powered device starts receiving power.
// - Budget-full lamp off whenever consumption is below 155 W.
// - Link/activity lamp: on with link, blinks with traffic, off without link.
// - Fast ports: 100 Mbps lamp on at 100 Mbps, off at 10 Mbps.
// - Gigabit ports: 1000 Mbps lamp on only for a 1000 Mbps link.
// - Gigabit ports: 100 Mbps lamp on only for a 100 Mbps link.
// - Power lamp green when a device is attached and powered without fault.
// - Power lamp red on a port fault (short, overcurrent, voltage, classification).
// - Power lamp off when no powered device is detected.
// - Shared ports: module lamp lit while a pluggable module sits in the slot.
// - Inserted module selects the fibre interface and disables that port's copper side.
//
// Package of constants shared by the panel lamp logic.
// Assumes a single 200 MHz clock and a 32-bit AXI4-Lite register bus.
package panel_led_pkg;
    // Clock and blink timing
    localparam int CLK_MHZ = 200;
    localparam int BLINK_HALF_MS = 100;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam logic [1:0] ACT_HOLD_TICKS = 2'h2;

    // Port counts
    localparam int FAST_PORTS = 24;
    localparam int GIG_PORTS = 4;
    localparam int SHARED_PORTS = 2;
    localparam int ALL_PORTS = FAST_PORTS + GIG_PORTS;

    // Speed codes on the per-port speed inputs
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // Consumption in units of 0.1 W; 155.0 W is the full mark
    localparam int POWER_W = 12;
    localparam logic [POWER_W-1:0] POWER_FULL_DW = 12'h60e;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] POWER_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] POE_EN_OFS = 8'h0c;
    localparam logic [7:0] LINK_OFS = 8'h10;
    localparam logic [7:0] SOURCING_OFS = 8'h14;

    // Field positions
    localparam int CTRL_IDLE_LEVEL_BIT = 0;
    localparam int STAT_BUDGET_FULL_BIT = 0;
    localparam int STAT_FAN_OK_BIT = 1;
    localparam int STAT_FAN_FAIL_BIT = 2;
    localparam int STAT_CPU_RUN_BIT = 3;
    localparam int STAT_MODULE_BIT = 4;

    // Reset values
    localparam logic CTRL_IDLE_LEVEL_RST = 1'b0;
    localparam logic [POWER_W-1:0] POWER_RST = 12'h000;
    localparam logic [FAST_PORTS-1:0] POE_EN_RST = 24'hffffff;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : panel_led_pkg

/* src/port_activity_lamp.sv */
// One port's link/activity lamp with traffic stretching.
// Assumes blink_tick is a one-cycle pulse shared by all ports.
`timescale 1ns/10ps
module port_activity_lamp
    import panel_led_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic blink_tick,
    input wire logic link_up,
    input wire logic activity,
    output logic lamp_r
);
    logic [1:0] hold_r;
    logic [1:0] hold_nxt;
    logic lamp_nxt;

    // A single short frame reloads the hold so it still shows a full blink
    assign hold_nxt = !link_up ? 2'h0 :
                      activity ? ACT_HOLD_TICKS :
                      (blink_tick && hold_r != 2'h0) ? hold_r - 2'h1 : hold_r;
    // Steady with link, toggle on ticks while traffic is held, dark without link
    assign lamp_nxt = !link_up ? 1'b0 :
                      (hold_r != 2'h0) ? (blink_tick ? !lamp_r : lamp_r) : 1'b1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_r <= 2'h0;
            lamp_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            lamp_r <= lamp_nxt;
        end
    end

    chk_link_lamp_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !link_up |=> !lamp_r) else $error("link lamp lit without link");
    chk_link_lamp_steady: assert property (@(posedge aclk) disable iff (!aresetn)
        (link_up && hold_r == 2'h0 && !activity) |=> lamp_r)
        else $error("link lamp not steady while idle");
endmodule : port_activity_lamp

/* testbench/panel_far_side.sv */
// Far-side model: frame sources feeding the panel and a watcher on two lamps.
// Assumes one clock; the bench flips act_req once for each frame.
`timescale 1ns/10ps
module panel_far_side
    import panel_led_pkg::*;
(
    input wire logic aclk,
    input wire logic [ALL_PORTS-1:0] act_req,
    input wire logic clr_cnt,
    input wire logic system_indicator,
    input wire logic lamp0,
    output logic [ALL_PORTS-1:0] activity = '0,
    output int ind_flips = 0,
    output int lamp_flips = 0
);
    logic [ALL_PORTS-1:0] req_r = '0;
    logic ind_r = 1'b0;
    logic lamp_r = 1'b0;

    // Single-cycle frame pulses, the hardest case for the stretch logic
    always_ff @(posedge aclk) begin
        req_r <= act_req;
        activity <= act_req ^ req_r;
        ind_r <= system_indicator;
        lamp_r <= lamp0;
        ind_flips <= clr_cnt ? 0 : ind_flips + int'(ind_r != system_indicator);
        lamp_flips <= clr_cnt ? 0 : lamp_flips + int'(lamp_r != lamp0);
    end
endmodule : panel_far_side

/* testbench/switch_front_panel_led_status_tb_top.sv */
// Self-checking bench for the panel lamp controller, registers over AXI4-Lite.
// Assumes a short blink period so that blinking is seen within a short run.
`timescale 1ns/10ps
module switch_front_panel_led_status_tb_top;
    import panel_led_pkg::*;
    localparam int unsigned BCYC = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cpu_running = 1'b0;
    logic fan_ok = 1'b0;
    logic fan_fail = 1'b0;
    logic clr_cnt = 1'b0;
    logic [ALL_PORTS-1:0] link_up = '0;
    logic [ALL_PORTS-1:0] act_req = '0;
    logic [2*ALL_PORTS-1:0] port_speed = '0;
    logic [FAST_PORTS-1:0] pd_detect = '0;
    logic [FAST_PORTS-1:0] pd_fault = '0;
    logic [SHARED_PORTS-1:0] module_present = '0;
    logic ind_out, fan_ok_lamp, fan_fail_lamp, budget_lamp;
    logic [ALL_PORTS-1:0] activity, lnk_lamp, s100;
    logic [GIG_PORTS-1:0] s1000;
    logic [FAST_PORTS-1:0] green, red, pwr_en;
    logic [SHARED_PORTS-1:0] mod_lamp, fib, cu;
    int ind_flips, lamp_flips;
    int num_errors = 0;
    int n_tests = 0;

    always #2.5 aclk = ~aclk;

    panel_led_ctrl #(.BLINK_CYC(BCYC)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_running(cpu_running), .fan_ok(fan_ok), .fan_fail(fan_fail),
        .link_up(link_up), .activity(activity), .port_speed(port_speed),
        .pd_detect(pd_detect), .pd_fault(pd_fault), .module_present(module_present),
        .system_indicator(ind_out), .fan_ok_lamp(fan_ok_lamp),
        .fan_fail_lamp(fan_fail_lamp), .power_budget_full_lamp(budget_lamp),
        .link_activity_lamp(lnk_lamp), .speed100_lamp(s100), .speed1000_lamp(s1000),
        .poe_green_lamp(green), .poe_red_lamp(red), .poe_power_en(pwr_en),
        .pluggable_module_slot_lamp(mod_lamp), .fiber_select(fib), .copper_enable(cu)
    );

    panel_far_side far (
        .aclk(aclk), .act_req(act_req), .clr_cnt(clr_cnt), .system_indicator(ind_out),
        .lamp0(lnk_lamp[0]), .activity(activity), .ind_flips(ind_flips),
        .lamp_flips(lamp_flips)
    );

    // Closing report, the single exit of the run
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bus got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_lamp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t lamp got %h exp %h", $time, got, exp);
        end
    endtask : chk_lamp

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw = 1'b1;
        bit w = 1'b1;
        bit b = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; k < 40 && b; k++) begin
            @(posedge aclk);
            if (aw && awready) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wready) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
            if (b && bvalid) begin
                bready <= 1'b0;
                b = 1'b0;
                chk_reg(32'(bresp), 32'(er));
            end
        end
        if (b) begin
            num_errors++;
            print_verdict();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit ar = 1'b1;
        bit r = 1'b1;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 40 && r; k++) begin
            @(posedge aclk);
            if (ar && arready) begin
                arvalid <= 1'b0;
                ar = 1'b0;
            end
            if (r && rvalid) begin
                rready <= 1'b0;
                r = 1'b0;
                chk_reg(rdata, ed);
                chk_reg(32'(rresp), 32'(er));
            end
        end
        if (r) begin
            num_errors++;
            print_verdict();
        end
    endtask : axi_rd

    // Reference speed lamps: lit only with link and a matching code
    function automatic logic [ALL_PORTS-1:0] exp_speed(input logic [1:0] code);
        logic [ALL_PORTS-1:0] e;
        for (int i = 0; i < ALL_PORTS; i++) begin
            e[i] = link_up[i] && (port_speed[2*i +: 2] == code);
        end
        return e;
    endfunction : exp_speed

    initial begin
        void'($urandom(4));
        tick(12);
        chk_lamp(32'({cu, mod_lamp, budget_lamp, ind_out}), 32'h30);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
        axi_rd(POWER_OFS, 32'(POWER_RST), RESP_OKAY);
        axi_rd(POE_EN_OFS, 32'(POE_EN_RST), RESP_OKAY);
        axi_wr(STATUS_OFS, 32'h1, RESP_SLVERR);
        axi_wr(8'h20, 32'h1, RESP_SLVERR);
        axi_rd(8'h20, 32'h0, RESP_SLVERR);
        // Random port states, no traffic and budget free
        for (int it = 0; it < 24; it++) begin
            fan_ok <= 1'($urandom);
            fan_fail <= 1'($urandom);
            link_up <= 28'($urandom);
            for (int i = 0; i < ALL_PORTS; i++) begin
                port_speed[2*i +: 2] <= 2'($urandom_range(i < FAST_PORTS ? 1 : 2));
            end
            pd_detect <= 24'($urandom);
            pd_fault <= 24'($urandom);
            module_present <= 2'($urandom);
            tick(3);
            chk_lamp(32'({fan_fail_lamp, fan_ok_lamp}), 32'({fan_fail, fan_ok}));
            chk_lamp(32'(s100), 32'(exp_speed(SPEED_100)));
            chk_lamp(32'(s1000), 32'(exp_speed(SPEED_1000) >> 24));
            chk_lamp(32'(lnk_lamp), 32'(link_up));
            chk_lamp(32'(red), 32'(pd_detect & pd_fault));
            chk_lamp(32'(green), 32'(pd_detect & ~pd_fault));
            chk_lamp(32'(pwr_en), 32'(pd_detect & ~pd_fault));
            chk_lamp(32'({fib, cu, mod_lamp}), 32'({module_present, ~module_present,
                module_present}));
            axi_rd(LINK_OFS, 32'(link_up), RESP_OKAY);
        end
        // Budget mark at its boundary, old ports kept, new ones refused
        pd_detect <= '0;
        pd_fault <= '0;
        axi_wr(POWER_OFS, 32'(POWER_FULL_DW) - 32'h1, RESP_OKAY);
        tick(3);
        chk_lamp(32'(budget_lamp), 32'h0);
        axi_wr(POWER_OFS, 32'(POWER_FULL_DW), RESP_OKAY);
        tick(3);
        chk_lamp(32'(budget_lamp), 32'h1);
        axi_rd(STATUS_OFS, 32'({module_present, cpu_running, fan_fail, fan_ok, 1'b1}),
            RESP_OKAY);
        pd_detect <= 24'h1;
        tick(4);
        chk_lamp(32'(pwr_en), 32'h0);
        axi_wr(POWER_OFS, 32'(POWER_FULL_DW) - 32'h1, RESP_OKAY);
        tick(4);
        chk_lamp(32'({budget_lamp, pwr_en}), 32'h1);
        axi_wr(POWER_OFS, 32'(POWER_FULL_DW), RESP_OKAY);
        pd_detect <= 24'h3;
        tick(4);
        chk_lamp(32'(pwr_en), 32'h1);
        axi_rd(SOURCING_OFS, 32'h1, RESP_OKAY);
        axi_wr(POE_EN_OFS, 32'h0, RESP_OKAY);
        wstrb <= 4'h1;
        axi_wr(POE_EN_OFS, 32'hffffffff, RESP_OKAY);
        axi_rd(POE_EN_OFS, 32'hff, RESP_OKAY);
        chk_lamp(32'(pwr_en), 32'h0);
        // System lamp blinks while running, then holds the chosen level
        cpu_running <= 1'b1;
        tick(4);
        clr_cnt <= 1'b1;
        tick(1);
        clr_cnt <= 1'b0;
        tick(10 * BCYC + 1);
        chk_lamp(32'(ind_flips), 32'd10);
        cpu_running <= 1'b0;
        axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
        tick(4);
        clr_cnt <= 1'b1;
        tick(1);
        clr_cnt <= 1'b0;
        tick(5 * BCYC);
        chk_lamp(32'({ind_flips[3:0], ind_out}), 32'h1);
        axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
        tick(4);
        chk_lamp(32'(ind_out), 32'h0);
        // One short frame on port 0 must show, port 27 stays steady
        link_up <= 28'h8000001;
        tick(4);
        clr_cnt <= 1'b1;
        tick(1);
        clr_cnt <= 1'b0;
        act_req[0] <= 1'b1;
        tick(6 * BCYC);
        chk_lamp(32'(lamp_flips), 32'd2);
        chk_lamp(32'(lnk_lamp), 32'h8000001);
        link_up <= '0;
        tick(3);
        chk_lamp(32'(lnk_lamp), 32'h0);
        print_verdict();
    end
endmodule : switch_front_panel_led_status_tb_top
